/* nic_core.sv */
// Interrupt controller with enable, pending, active and priority state.
`timescale 1ns/10ps
// Notes on behaviour
// - Enable-set writes ones enable; reads show enables.
// - Pending enabled interrupts activate by priority.
// - Disabled interrupts pend but never activate.
// - Enable-clear writes ones disable; reads show enables.
// - Pending-set writes ones pend; reads show pending.
// - Set-pending works if already pending or disabled.
// - Pending-clear writes ones unpend; reads show pending.
// - Pending-clear leaves active state alone.
// - Eight-bit priority fields, four per word.
// - Only priority bits 7:6 stored; rest zero.
// - Lower priority value is more urgent.
// - Interrupt M in word M/4, lane M%4.
// - Requests sampled on rising clock edge.
// - Entry clears pending and sets active.
// - Pend on high-not-active, rising edge, or software.
// - Level: on return, pend if request high.
// - Pulse during active gives active-and-pending.
// - Level clear ignored while request still high.
// - Pulse clear: pending to inactive, both to active.
// - Priority levels 0 to 192 in steps of 64.
module nic_core
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Peripheral request lines and their sensing mode (1 = level).
  input wire logic [31:0] irq_req_i,
  input wire logic [31:0] irq_level_i,
  // Register access from the core.
  input wire nic_pkg::reg_req_t req_i,
  output logic [31:0] rdata_o,
  // Service routine entry and return from the core.
  input wire nic_pkg::core_evt_t evt_i,
  // Selected interrupt towards the core.
  output logic take_valid_o,
  output logic [4:0] take_num_o,
  output logic [1:0] take_prio_o
);

  // ---------------------------------------------------------------
  // Request synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [31:0] sync1_r, sync1_nxt; // First synchroniser stage.
  logic [31:0] sync2_r, sync2_nxt; // Second synchroniser stage.
  logic [31:0] prev_r, prev_nxt; // Previous sampled request.
  logic [31:0] rise; // Rising edge seen this cycle.

  // Two flip-flops guard against metastable request lines.
  always_comb
  begin
    sync1_nxt = irq_req_i;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
  end

  // Registers the synchroniser chain.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_r <= nic_pkg::RST_WORD;
      sync2_r <= nic_pkg::RST_WORD;
      prev_r <= nic_pkg::RST_WORD;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Edges come from the second stage only.
  assign rise = sync2_r & ~prev_r;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic [31:0] en_set_w, en_clr_w, pd_set_w, pd_clr_w; // Write masks.
  logic prio_wr; // Write hits a priority word.
  logic [2:0] prio_idx; // Priority word index.

  // Word-wide strobes; writes of zero bits leave state as is.
  always_comb
  begin
    en_set_w = '0;
    en_clr_w = '0;
    pd_set_w = '0;
    pd_clr_w = '0;
    if (req_i.wr)
    begin
      case (req_i.addr)
        nic_pkg::OFS_ENABLE_SET: en_set_w = req_i.wdata;
        nic_pkg::OFS_ENABLE_CLR: en_clr_w = req_i.wdata;
        nic_pkg::OFS_PEND_SET: pd_set_w = req_i.wdata;
        nic_pkg::OFS_PEND_CLR: pd_clr_w = req_i.wdata;
        default: en_set_w = '0;
      endcase
    end
  end

  // Whole-word priority writes only; index is offset / 4 within block.
  assign prio_wr = req_i.wr && req_i.addr >= nic_pkg::OFS_PRIO_BASE
    && req_i.addr <= nic_pkg::OFS_PRIO_LAST;
  assign prio_idx = 3'(req_i.addr[4:2]);

  // ---------------------------------------------------------------
  // Per-interrupt state
  // ---------------------------------------------------------------
  logic [31:0] en_r, en_nxt; // Enable vector.
  logic [31:0] pd_r, pd_nxt; // Pending vector.
  logic [31:0] act_r, act_nxt; // Active vector.
  logic [1:0] prio_r [32]; // Stored priority bits 7:6.
  logic [1:0] prio_nxt [32]; // Next stored priority.

  genvar g;
  generate
    for (g = 0; g < nic_pkg::NUM_IRQ; g++)
    begin : g_irq
      logic hit; // Core event names this interrupt.
      assign hit = (evt_i.irq_num == 5'(g));

      // Next state of one interrupt; bit g is request line g.
      always_comb
      begin
        en_nxt[g] = (en_r[g] | en_set_w[g]) & ~en_clr_w[g];
        act_nxt[g] = act_r[g];
        pd_nxt[g] = pd_r[g];
        prio_nxt[g] = prio_r[g];
        // Software clear first so hardware sets below win.
        if (pd_clr_w[g])
        begin
          if (irq_level_i[g])
            pd_nxt[g] = pd_r[g] & sync2_r[g];
          else
            pd_nxt[g] = 1'b0;
        end
        // Level high and not active, or a rising edge, pends.
        if ((irq_level_i[g] && sync2_r[g] && !act_r[g]) || rise[g])
          pd_nxt[g] = 1'b1;
        // Software set works whatever enable says.
        if (pd_set_w[g])
          pd_nxt[g] = 1'b1;
        // Entry moves pending into active.
        if (evt_i.enter && hit)
        begin
          act_nxt[g] = 1'b1;
          pd_nxt[g] = rise[g];
        end
        // Return resamples a level request.
        if (evt_i.leave && hit)
        begin
          act_nxt[g] = 1'b0;
          if (irq_level_i[g] && sync2_r[g])
            pd_nxt[g] = 1'b1;
        end
        // Priority field keeps only its top two bits.
        if (prio_wr && prio_idx == 3'(g / nic_pkg::PRIO_LANES))
          prio_nxt[g] = req_i.wdata[(g % nic_pkg::PRIO_LANES)
            * nic_pkg::LANE_W + nic_pkg::PRIO_LO +: 2];
      end

      // Registers one interrupt's state.
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          en_r[g] <= 1'b0;
          pd_r[g] <= 1'b0;
          act_r[g] <= 1'b0;
          prio_r[g] <= nic_pkg::RST_PRIO;
        end
        else
        begin
          en_r[g] <= en_nxt[g];
          pd_r[g] <= pd_nxt[g];
          act_r[g] <= act_nxt[g];
          prio_r[g] <= prio_nxt[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Selection of the most urgent candidate
  // ---------------------------------------------------------------
  logic [5:0] best_num; // Winning interrupt or none.
  logic [1:0] best_prio; // Its priority.

  // Lowest value wins; ties go to the lowest line number.
  always_comb
  begin
    best_num = nic_pkg::IRQ_NONE;
    best_prio = 2'h3;
    for (int i = nic_pkg::NUM_IRQ - 1; i >= 0; i--)
    begin
      // Only pending and enabled lines compete.
      if (pd_r[i] && en_r[i] && prio_r[i] <= best_prio)
      begin
        best_num = 6'(i);
        best_prio = prio_r[i];
      end
    end
    // With no candidate the offered priority reads zero, as after reset.
    if (best_num[5])
      best_prio = nic_pkg::RST_PRIO;
  end

  // ---------------------------------------------------------------
  // Read data and selection outputs
  // ---------------------------------------------------------------
  logic [31:0] rdata_nxt; // Read mux result.
  logic [31:0] prio_word; // Assembled priority word.

  // Builds a priority word, low six bits of each lane as zero.
  always_comb
  begin
    prio_word = '0;
    for (int l = 0; l < nic_pkg::PRIO_LANES; l++)
      prio_word[l * nic_pkg::LANE_W + nic_pkg::PRIO_LO +: 2] =
        prio_r[{prio_idx, 2'(l)}];
  end

  // Read mux; unmapped offsets read zero.
  always_comb
  begin
    rdata_nxt = rdata_o;
    if (req_i.rd)
    begin
      case (req_i.addr)
        nic_pkg::OFS_ENABLE_SET: rdata_nxt = en_r;
        nic_pkg::OFS_ENABLE_CLR: rdata_nxt = en_r;
        nic_pkg::OFS_PEND_SET: rdata_nxt = pd_r;
        nic_pkg::OFS_PEND_CLR: rdata_nxt = pd_r;
        default:
          if (req_i.addr >= nic_pkg::OFS_PRIO_BASE
            && req_i.addr <= nic_pkg::OFS_PRIO_LAST)
            rdata_nxt = prio_word;
          else
            rdata_nxt = '0;
      endcase
    end
  end

  // Registers read data and selection for the core.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= nic_pkg::RST_WORD;
      take_valid_o <= 1'b0;
      take_num_o <= 5'h00;
      take_prio_o <= 2'h0;
    end
    else
    begin
      rdata_o <= rdata_nxt;
      take_valid_o <= ~best_num[5];
      take_num_o <= best_num[4:0];
      take_prio_o <= best_prio;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Lines 0, 3, 7 and 12 are the ones the bench drives through each path.
  enable_set_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    en_set_w[0] && !en_clr_w[0] |=> en_r[0])
    else $error("enable set did not enable line 0");
  enable_clear_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    en_clr_w[3] |=> !en_r[3])
    else $error("enable clear did not disable line 3");
  disabled_never_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    take_valid_o && $stable(en_r) |-> en_r[take_num_o])
    else $error("disabled interrupt selected");
  pend_set_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    pd_set_w[3] && !(evt_i.enter && evt_i.irq_num == 5'h03)
    |=> pd_r[3])
    else $error("pending set did not pend line 3");
  clear_active_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    pd_clr_w[7] && !evt_i.enter && !evt_i.leave
    |=> act_r[7] == $past(act_r[7]))
    else $error("pending clear changed active state");
  pulse_clear_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    pd_clr_w[7] && !irq_level_i[7] && !rise[7] && !pd_set_w[7]
    |=> !pd_r[7])
    else $error("pulse clear left line 7 pending");
  level_clear_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    pd_clr_w[12] && irq_level_i[12] && sync2_r[12] && pd_r[12]
    && !evt_i.enter |=> pd_r[12])
    else $error("level clear dropped pending line 12");
  entry_moves_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    evt_i.enter && evt_i.irq_num == 5'h07 && !rise[7]
    |=> act_r[7] && !pd_r[7])
    else $error("entry did not activate line 7");
  edge_pends_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(sync2_r[7]) |=> pd_r[7])
    else $error("rising edge did not pend line 7");
  level_return_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    evt_i.leave && evt_i.irq_num == 5'h0C && irq_level_i[12]
    && sync2_r[12] |=> pd_r[12] && !act_r[12])
    else $error("level return did not repend line 12");
  urgent_wins_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    best_num != nic_pkg::IRQ_NONE |-> ##1 take_valid_o
    && take_prio_o == $past(best_prio))
    else $error("selection lost priority");
  prio_low_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    req_i.rd && req_i.addr == nic_pkg::OFS_PRIO_BASE
    |=> rdata_o[5:0] == 6'h00)
    else $error("priority low bits not zero");

  enter_cov_c: cover property (@(posedge clk_i) evt_i.enter);
  act_pend_c: cover property (@(posedge clk_i) act_r[0] && pd_r[0]);
  take_cov_c: cover property (@(posedge clk_i) take_valid_o);
  level_ret_c: cover property (@(posedge clk_i)
    evt_i.leave && irq_level_i[evt_i.irq_num]);

endmodule // nic_core

/* nic_pkg.sv */
// Package with register map, field layout and carriers for the irq controller.
package nic_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets within the controller window)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_ENABLE_SET = 12'h100; // Enable-set word.
  localparam logic [11:0] OFS_ENABLE_CLR = 12'h180; // Enable-clear word.
  localparam logic [11:0] OFS_PEND_SET = 12'h200; // Pending-set word.
  localparam logic [11:0] OFS_PEND_CLR = 12'h280; // Pending-clear word.
  localparam logic [11:0] OFS_PRIO_BASE = 12'h400; // First priority word.
  localparam logic [11:0] OFS_PRIO_LAST = 12'h41C; // Last priority word.

  // ---------------------------------------------------------------
  // Sizes, field positions and reset values
  // ---------------------------------------------------------------
  localparam int NUM_IRQ = 32; // Number of request lines.
  localparam int PRIO_LANES = 4; // Priority fields per word.
  localparam int LANE_W = 8; // Width of one priority field.
  localparam int PRIO_HI = 7; // Top stored bit of a field.
  localparam int PRIO_LO = 6; // Lowest stored bit of a field.
  localparam logic [31:0] RST_WORD = 32'h00000000; // Reset of vectors.
  localparam logic [1:0] RST_PRIO = 2'h0; // Reset of stored priority.
  localparam logic [5:0] IRQ_NONE = 6'h20; // Code for no candidate.

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // One register access from the core.
  typedef struct packed {
    logic wr; // Write strobe.
    logic rd; // Read strobe.
    logic [11:0] addr; // Word-aligned byte offset.
    logic [31:0] wdata; // Write data.
  } reg_req_t;

  // Core handshake: entry to and return from a service routine.
  typedef struct packed {
    logic enter; // Core enters the routine of irq_num.
    logic leave; // Core returns from the routine of irq_num.
    logic [4:0] irq_num; // Interrupt being entered or left.
  } core_evt_t;

endpackage

/* irq_env_model.sv */
// Model of the request lines and the core around the irq controller.
`timescale 1ns/10ps
module irq_env_model
(
  // Clock.
  input wire logic clk_i,
  // Selection offered by the controller.
  input wire logic take_valid_i,
  input wire logic [4:0] take_num_i,
  // Request lines and core events towards the controller.
  output logic [31:0] irq_req_o,
  output nic_pkg::core_evt_t evt_o
);
  // Lines rest low and the core is idle at start.
  initial
  begin
    irq_req_o = 32'h0;
    evt_o = '0;
  end

  // Holds a request high for cyc whole cycles; a cyc of zero gives a 1 ns pulse.
  task automatic pulse(input logic [4:0] n, input int cyc);
    @(posedge clk_i);
    #1 irq_req_o[n] = 1'b1;
    repeat (cyc) @(posedge clk_i);
    #1 irq_req_o[n] = 1'b0;
  endtask

  // Sets a level request to a new value.
  task automatic level(input logic [4:0] n, input logic v);
    @(posedge clk_i);
    #1 irq_req_o[n] = v;
  endtask

  // Enters a routine only once the controller offers that interrupt.
  task automatic enter(input logic [4:0] n, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      @(posedge clk_i);
      #1 ok = take_valid_i && take_num_i == n;
    end
    if (ok)
    begin
      evt_o = {1'b1, 1'b0, n};
      @(posedge clk_i);
      #1 evt_o = '0;
    end
  endtask

  // Returns from the routine of one interrupt.
  task automatic leave(input logic [4:0] n);
    @(posedge clk_i);
    #1 evt_o = {1'b0, 1'b1, n};
    @(posedge clk_i);
    #1 evt_o = '0;
  endtask
endmodule // irq_env_model

/* testbench.sv */
// Self-checking testbench for the irq controller.
`timescale 1ns/10ps
module testbench;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] irq_req;
  logic [31:0] irq_level = 32'h0000_1000; // Line 12 is level, rest pulse.
  nic_pkg::reg_req_t req = '0;
  logic [31:0] rdata;
  nic_pkg::core_evt_t evt;
  logic take_valid;
  logic [4:0] take_num;
  logic [1:0] take_prio;
  logic ok;
  int miscompares = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  nic_core dut_u (.clk_i(clk), .resetn_i(resetn), .irq_req_i(irq_req),
    .irq_level_i(irq_level), .req_i(req), .rdata_o(rdata), .evt_i(evt),
    .take_valid_o(take_valid), .take_num_o(take_num),
    .take_prio_o(take_prio));

  irq_env_model part_u (.clk_i(clk), .take_valid_i(take_valid),
    .take_num_i(take_num), .irq_req_o(irq_req), .evt_o(evt));

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  // Counts a compare and reports any difference.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask

  // One aligned whole-word write.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '0;
  endtask

  // One aligned read; data is valid the cycle after the strobe.
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    #1 req = '0;
    check("rdata", rdata, e);
  endtask

  // Compares the offered interrupt once selection has settled.
  task automatic tk(input logic v, input logic [4:0] n, input logic [1:0] p);
    repeat (2) @(posedge clk);
    #1 check("take", {24'h0, take_valid, take_num, take_prio},
                     v ? {24'h0, v, n, p} : 32'h0);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    rd(12'h100, 32'h0);
    rd(12'h200, 32'h0);
    rd(12'h300, 32'h0);
    wr(12'h100, 32'hA5A5_0F0F);
    rd(12'h100, 32'hA5A5_0F0F);
    rd(12'h180, 32'hA5A5_0F0F);
    wr(12'h180, 32'h0000_0F00);
    wr(12'h100, 32'h0);
    rd(12'h100, 32'hA5A5_000F);
    for (int k = 0; k < 8; k++)
      wr(nic_pkg::OFS_PRIO_BASE + 12'(4 * k), 32'h1F5F_9FDF + 32'(k));
    for (int k = 0; k < 8; k++)
      rd(nic_pkg::OFS_PRIO_BASE + 12'(4 * k), 32'h0040_80C0);
    done("registers");
    wr(12'h400, 32'h00C0_0000); // Irq 2 at 192, irq 3 at 0.
    wr(12'h404, 32'h0000_8000); // Irq 5 at 128.
    wr(12'h408, 32'h0000_4000); // Irq 9 at 64.
    wr(12'h40C, 32'h0);
    wr(12'h180, 32'hFFFF_FFFF);
    wr(12'h200, 32'h0000_0008);
    wr(12'h200, 32'h0000_0008);
    rd(12'h200, 32'h0000_0008);
    tk(1'b0, 5'h0, 2'h0);
    wr(12'h100, 32'h0000_0008);
    tk(1'b1, 5'h3, 2'h0);
    wr(12'h280, 32'h0000_0008);
    rd(12'h200, 32'h0);
    done("pending");
    wr(12'h100, 32'h0000_0224);
    wr(12'h200, 32'h0000_0224);
    tk(1'b1, 5'h9, 2'h1);
    wr(12'h280, 32'h0000_0200);
    tk(1'b1, 5'h5, 2'h2);
    wr(12'h280, 32'h0000_0020);
    tk(1'b1, 5'h2, 2'h3);
    wr(12'h280, 32'h0000_0004);
    done("priority");
    wr(12'h100, 32'h0000_1080);
    part_u.pulse(5'h7, 1);
    repeat (4) @(posedge clk);
    rd(12'h200, 32'h0000_0080);
    part_u.enter(5'h7, ok);
    check("enter", {31'h0, ok}, 32'h1);
    rd(12'h200, 32'h0);
    part_u.pulse(5'h7, 1);
    repeat (4) @(posedge clk);
    rd(12'h200, 32'h0000_0080);
    wr(12'h280, 32'h0000_0080);
    rd(12'h200, 32'h0);
    part_u.pulse(5'h7, 2);
    repeat (4) @(posedge clk);
    part_u.leave(5'h7);
    rd(12'h200, 32'h0000_0080);
    wr(12'h280, 32'h0000_0080);
    rd(12'h200, 32'h0);
    done("pulse");
    part_u.level(5'hC, 1'b1);
    repeat (4) @(posedge clk);
    rd(12'h200, 32'h0000_1000);
    part_u.enter(5'hC, ok);
    repeat (4) @(posedge clk);
    rd(12'h200, 32'h0);
    part_u.leave(5'hC);
    rd(12'h200, 32'h0000_1000);
    wr(12'h280, 32'h0000_1000);
    rd(12'h200, 32'h0000_1000);
    part_u.level(5'hC, 1'b0);
    repeat (4) @(posedge clk);
    wr(12'h280, 32'h0000_1000);
    rd(12'h200, 32'h0);
    done("level");
    give_verdict();
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule // testbench
